// [rtl/gpp_pkg.sv]
package gpp_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register map, one register per address
  localparam logic [ADDR_W-1:0] REG_B_PINS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_B_LATCH = 4'h1;
  localparam logic [ADDR_W-1:0] REG_B_DIR = 4'h2;
  localparam logic [ADDR_W-1:0] REG_B_PULLUP = 4'h3;
  localparam logic [ADDR_W-1:0] REG_B_CHG_EN = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SLEW = 4'h5;
  localparam logic [ADDR_W-1:0] REG_INT_MAIN = 4'h6;
  localparam logic [ADDR_W-1:0] REG_INT_EDGE = 4'h7;
  localparam logic [ADDR_W-1:0] REG_INT_EXT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_ANSEL_HI = 4'h9;
  localparam logic [ADDR_W-1:0] REG_C_PINS = 4'ha;
  localparam logic [ADDR_W-1:0] REG_C_LATCH = 4'hb;
  localparam logic [ADDR_W-1:0] REG_C_DIR = 4'hc;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'hd;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'he;

  // Implemented bits per register; all others read 0
  localparam logic [7:0] MASK_CHG_EN = 8'hf0;
  localparam logic [7:0] MASK_SLEW = 8'h1f;
  localparam logic [7:0] MASK_ANSEL = 8'h1f;
  localparam logic [7:0] MASK_IRQ = 8'h03;

  // Reset values
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_SLEW = 8'h00;
  localparam logic RST_PULLUP_DIS = 1'b1;
  localparam logic RST_RELOCATE = 1'b1;

  // Field positions
  localparam int BIT_CHG_FLAG = 0;
  localparam int BIT_CHG_IRQ_EN = 3;
  localparam int BIT_PULLUP_DIS = 7;
  localparam int BIT_PROG_CLK = 6;
  localparam int BIT_PROG_DATA = 7;
  localparam int BIT_CCP_ALT = 3;
  localparam int BIT_CCP_DEF = 1;
  localparam int BIT_STAT_CHG = 0;
  localparam int BIT_STAT_PROG = 1;
  localparam int BIT_CFG_RELOCATE = 0;
  localparam int BIT_CFG_ANALOG = 1;
  localparam logic [7:0] PROG_PINS = 8'hc0;

  typedef enum logic [1:0] {INIT_SYNC0, INIT_SYNC1, INIT_LOAD, INIT_DONE} gpp_init_e;

  // Analog select bits onto second-port pins 0..4
  function automatic logic [7:0] gpp_ansel_pins(input logic [4:0] ans);
    gpp_ansel_pins = {3'h0, ans[3], ans[1], ans[0], ans[2], ans[4]};
  endfunction : gpp_ansel_pins

endpackage : gpp_pkg

// [rtl/gpp_port.sv]
// Function
// - third port is eight individually directed pins
// - direction bit 1 disables the output driver
// - direction bit 0 drives output latch value
// - latch readable; read-modify-write uses latch value
// - capture pin on third bit1, relocatable, default 1
// - serial peripherals override third-port pin direction
// - after reset all third-port pins are inputs
// - direction read returns stored value despite overrides
// - second-port bits 0..7 have weak pull-ups
// - programming mode makes bit 6 clock input
// - programming mode makes bit 7 bidirectional data
// - programming mode disables other functions on 6,7
// - analog-default bit sets analog pins after reset
// - unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
module gpp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [gpp_pkg::ADDR_W-1:0] addr,
  input wire logic [gpp_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [gpp_pkg::DATA_W-1:0] rdata,
  output logic irq,
  // Configuration straps
  input wire logic cfg_relocate,
  input wire logic cfg_analog_default,
  // Second-port pins
  input wire logic [7:0] second_port_pin_levels_in,
  output logic [7:0] second_port_pin_levels_out,
  output logic [7:0] second_port_pin_levels_oe,
  output logic [7:0] second_port_pin_levels_pullup,
  output logic [7:0] second_port_pin_levels_analog,
  // Third-port pins
  input wire logic [7:0] third_port_pin_levels_in,
  output logic [7:0] third_port_pin_levels_out,
  output logic [7:0] third_port_pin_levels_oe,
  output logic [4:0] slew_ctrl,
  // Serial peripherals on the third port
  input wire logic [7:0] periph_c_en,
  input wire logic [7:0] periph_c_oe,
  input wire logic [7:0] periph_c_out,
  output logic [7:0] periph_c_in,
  // Capture/compare unit two
  input wire logic capture_compare_unit_two_en,
  input wire logic capture_compare_unit_two_drive,
  input wire logic capture_compare_unit_two_out,
  output logic capture_compare_unit_two_in,
  // Serial programming and debug
  input wire logic prog_en,
  input wire logic pgd_oe,
  input wire logic pgd_out,
  output logic pgc_clk,
  output logic pgd_in
);
  import gpp_pkg::*;

  typedef struct packed {
    logic [7:0] b_s1;
    logic [7:0] b_s2;
    logic [7:0] c_s1;
    logic [7:0] c_s2;
    logic [1:0] cfg_s1;
    logic [1:0] cfg_s2;
    gpp_init_e init;
    logic relocate;
    logic [7:0] second_port_output_latch;
    logic [7:0] second_port_direction;
    logic [7:0] second_port_pullup_enable;
    logic [7:0] second_port_change_irq_enable;
    logic [4:0] slew;
    logic chg_ie;
    logic chg_flag;
    logic pu_dis;
    logic [4:0] ansel;
    logic [7:0] third_port_output_latch;
    logic [7:0] third_port_direction;
    logic [7:0] snap;
    logic [1:0] stat;
    logic [1:0] mask;
    logic prog_d;
    logic chg_irq_d;
    logic [7:0] rdata;
    logic [7:0] pb_out;
    logic [7:0] pb_oe;
    logic [7:0] pb_pu;
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
  } gpp_state_s;

  gpp_state_s s_q;
  gpp_state_s s_d;

  logic [7:0] analog_pins;
  logic [7:0] b_dig;
  logic [7:0] prog_mask;
  logic [7:0] chg_hit;
  logic [1:0] irq_ev;
  logic ccp_on_b;
  logic ccp_on_c;
  logic [7:0] rd_val;

  assign analog_pins = gpp_ansel_pins(s_q.ansel);
  assign b_dig = s_q.b_s2 & ~analog_pins;
  assign prog_mask = prog_en ? PROG_PINS : 8'h00;
  assign ccp_on_b = capture_compare_unit_two_en & ~s_q.relocate;
  assign ccp_on_c = capture_compare_unit_two_en & s_q.relocate;
  // Enabled upper input pins that differ from the last pin read
  assign chg_hit = s_q.second_port_change_irq_enable & s_q.second_port_direction & (s_q.b_s2 ^ s_q.snap) & MASK_CHG_EN & ~prog_mask;
  assign irq_ev = {prog_en & ~s_q.prog_d, s_q.chg_flag & s_q.chg_ie & ~s_q.chg_irq_d};

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    case (addr)
      REG_B_PINS: rd_val = b_dig;
      REG_B_LATCH: rd_val = s_q.second_port_output_latch;
      REG_B_DIR: rd_val = s_q.second_port_direction;
      REG_B_PULLUP: rd_val = s_q.second_port_pullup_enable;
      REG_B_CHG_EN: rd_val = s_q.second_port_change_irq_enable & MASK_CHG_EN;
      REG_SLEW: rd_val = {3'h0, s_q.slew};
      REG_INT_MAIN: begin
        rd_val[BIT_CHG_IRQ_EN] = s_q.chg_ie;
        rd_val[BIT_CHG_FLAG] = s_q.chg_flag;
      end
      REG_INT_EDGE: rd_val[BIT_PULLUP_DIS] = s_q.pu_dis;
      REG_ANSEL_HI: rd_val = {3'h0, s_q.ansel};
      REG_C_PINS: rd_val = s_q.c_s2;
      REG_C_LATCH: rd_val = s_q.third_port_output_latch;
      REG_C_DIR: rd_val = s_q.third_port_direction;
      REG_IRQ_STAT: rd_val = {6'h00, s_q.stat};
      REG_IRQ_MASK: rd_val = {6'h00, s_q.mask};
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.b_s1 = second_port_pin_levels_in;
    s_d.b_s2 = s_q.b_s1;
    s_d.c_s1 = third_port_pin_levels_in;
    s_d.c_s2 = s_q.c_s1;
    s_d.cfg_s1[BIT_CFG_RELOCATE] = cfg_relocate;
    s_d.cfg_s1[BIT_CFG_ANALOG] = cfg_analog_default;
    s_d.cfg_s2 = s_q.cfg_s1;
    s_d.prog_d = prog_en;
    s_d.chg_irq_d = s_q.chg_flag & s_q.chg_ie;

    // Straps are caught once they have passed the synchroniser
    unique case (s_q.init)
      INIT_SYNC0: s_d.init = INIT_SYNC1;
      INIT_SYNC1: s_d.init = INIT_LOAD;
      INIT_LOAD: begin
        s_d.relocate = s_q.cfg_s2[BIT_CFG_RELOCATE];
        s_d.ansel = s_q.cfg_s2[BIT_CFG_ANALOG] ? MASK_ANSEL[4:0] : 5'h00;
        s_d.init = INIT_DONE;
      end
      INIT_DONE: s_d.init = INIT_DONE;
    endcase

    // Register writes; port writes land in the latch
    if (wr_en) begin
      case (addr)
        REG_B_PINS, REG_B_LATCH: s_d.second_port_output_latch = wdata;
        REG_B_DIR: s_d.second_port_direction = wdata;
        REG_B_PULLUP: s_d.second_port_pullup_enable = wdata;
        REG_B_CHG_EN: s_d.second_port_change_irq_enable = wdata & MASK_CHG_EN;
        REG_SLEW: s_d.slew = wdata[4:0];
        REG_INT_MAIN: begin
          s_d.chg_ie = wdata[BIT_CHG_IRQ_EN];
          s_d.chg_flag = wdata[BIT_CHG_FLAG];
        end
        REG_INT_EDGE: s_d.pu_dis = wdata[BIT_PULLUP_DIS];
        REG_ANSEL_HI: s_d.ansel = wdata[4:0];
        REG_C_PINS, REG_C_LATCH: s_d.third_port_output_latch = wdata;
        REG_C_DIR: s_d.third_port_direction = wdata;
        REG_IRQ_MASK: s_d.mask = wdata[1:0];
        default: s_d.mask = s_q.mask;
      endcase
    end

    // A mismatch sets the flag even in the cycle it is cleared
    if (|chg_hit) begin
      s_d.chg_flag = 1'b1;
    end
    if (rd_en && addr == REG_B_PINS) begin
      s_d.snap = s_q.b_s2;
    end

    // Sticky status: read clears, new event wins
    s_d.stat = ((rd_en && addr == REG_IRQ_STAT) ? 2'h0 : s_q.stat) | irq_ev;
    s_d.rdata = rd_en ? rd_val : 8'h00;

    // Second-port pin drive
    s_d.pb_out = s_q.second_port_output_latch;
    s_d.pb_oe = ~s_q.second_port_direction;
    if (ccp_on_b) begin
      s_d.pb_out[BIT_CCP_ALT] = capture_compare_unit_two_out;
      s_d.pb_oe[BIT_CCP_ALT] = capture_compare_unit_two_drive;
    end
    if (prog_en) begin
      s_d.pb_oe[BIT_PROG_CLK] = 1'b0;
      s_d.pb_oe[BIT_PROG_DATA] = pgd_oe;
      s_d.pb_out[BIT_PROG_DATA] = pgd_out;
    end
    s_d.pb_pu = ~s_d.pb_oe & s_q.second_port_pullup_enable & ~analog_pins & ~prog_mask & {8{~s_q.pu_dis}};

    // Third-port pin drive
    s_d.pc_out = s_q.third_port_output_latch;
    s_d.pc_oe = ~s_q.third_port_direction;
    if (ccp_on_c) begin
      s_d.pc_out[BIT_CCP_DEF] = capture_compare_unit_two_out;
      s_d.pc_oe[BIT_CCP_DEF] = capture_compare_unit_two_drive;
    end
    s_d.pc_oe = (s_d.pc_oe & ~periph_c_en) | (periph_c_oe & periph_c_en);
    s_d.pc_out = (s_d.pc_out & ~periph_c_en) | (periph_c_out & periph_c_en);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.init <= INIT_SYNC0;
      s_q.relocate <= RST_RELOCATE;
      s_q.second_port_output_latch <= RST_LATCH;
      s_q.third_port_output_latch <= RST_LATCH;
      s_q.second_port_direction <= RST_DIR;
      s_q.third_port_direction <= RST_DIR;
      s_q.second_port_pullup_enable <= RST_PULLUP;
      s_q.slew <= RST_SLEW[4:0];
      s_q.pu_dis <= RST_PULLUP_DIS;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign irq = |(s_q.stat & s_q.mask);
  assign second_port_pin_levels_out = s_q.pb_out;
  assign second_port_pin_levels_oe = s_q.pb_oe;
  assign second_port_pin_levels_pullup = s_q.pb_pu;
  assign second_port_pin_levels_analog = analog_pins & ~prog_mask;
  assign third_port_pin_levels_out = s_q.pc_out;
  assign third_port_pin_levels_oe = s_q.pc_oe;
  assign slew_ctrl = s_q.slew;
  assign periph_c_in = s_q.c_s2;
  assign capture_compare_unit_two_in = s_q.relocate ? s_q.c_s2[BIT_CCP_DEF] : s_q.b_s2[BIT_CCP_ALT];
  assign pgc_clk = prog_en & s_q.b_s2[BIT_PROG_CLK];
  assign pgd_in = prog_en & s_q.b_s2[BIT_PROG_DATA];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_third_port_output_latch_write;
    wr_en && addr == REG_C_LATCH;
  endsequence

  sequence s_third_port_output_latch_read;
    rd_en && addr == REG_C_LATCH;
  endsequence

  property p_c_input;
    (~|periph_c_en && !ccp_on_c) |=> ((third_port_pin_levels_oe & $past(s_q.third_port_direction)) == 8'h00);
  endproperty
  a_c_input: assert property (p_c_input) else $error("input pin still driven");

  property p_c_output;
    (~|periph_c_en && !ccp_on_c) |=> (third_port_pin_levels_oe == ~$past(s_q.third_port_direction)) && (third_port_pin_levels_out == $past(s_q.third_port_output_latch));
  endproperty
  a_c_output: assert property (p_c_output) else $error("output pin not driving latch");

  property p_latch_rmw;
    s_third_port_output_latch_write ##1 s_third_port_output_latch_read |=> rdata == $past(wdata, 2);
  endproperty
  a_latch_rmw: assert property (p_latch_rmw) else $error("latch readback differs from write");

  property p_ccp_alt;
    (s_q.init == INIT_DONE && ccp_on_b) |=> second_port_pin_levels_oe[BIT_CCP_ALT] == $past(capture_compare_unit_two_drive);
  endproperty
  a_ccp_alt: assert property (p_ccp_alt) else $error("relocated capture pin not driven");

  property p_ccp_default;
    s_q.init != INIT_DONE |-> s_q.relocate;
  endproperty
  a_ccp_default: assert property (p_ccp_default) else $error("relocation bit not at default");

  property p_periph_dir;
    1'b1 |=> ((third_port_pin_levels_oe ^ $past(periph_c_oe)) & $past(periph_c_en)) == 8'h00;
  endproperty
  a_periph_dir: assert property (p_periph_dir) else $error("peripheral direction not applied");

  property p_reset_inputs;
    s_q.init == INIT_SYNC1 |-> third_port_pin_levels_oe == 8'h00 && s_q.third_port_direction == RST_DIR;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("third port not input after reset");

  property p_dir_read;
    (rd_en && addr == REG_C_DIR) |=> rdata == $past(s_q.third_port_direction);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read not stored value");

  property p_pullup;
    1'b1 |=> second_port_pin_levels_pullup == (~second_port_pin_levels_oe & $past(s_q.second_port_pullup_enable) & ~$past(analog_pins)
                              & ~$past(prog_mask) & {8{~$past(s_q.pu_dis)}});
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");

  property p_prog_clk;
    prog_en |=> !second_port_pin_levels_oe[BIT_PROG_CLK] && !second_port_pin_levels_pullup[BIT_PROG_CLK];
  endproperty
  a_prog_clk: assert property (p_prog_clk) else $error("programming clock pin driven");

  property p_prog_data;
    prog_en |=> second_port_pin_levels_oe[BIT_PROG_DATA] == $past(pgd_oe) && (!$past(pgd_oe) || second_port_pin_levels_out[BIT_PROG_DATA] == $past(pgd_out));
  endproperty
  a_prog_data: assert property (p_prog_data) else $error("programming data pin wrong");

  property p_prog_excl;
    prog_en |-> !chg_hit[BIT_PROG_CLK] && !chg_hit[BIT_PROG_DATA] && second_port_pin_levels_analog[7:6] == 2'h0;
  endproperty
  a_prog_excl: assert property (p_prog_excl) else $error("other function on programming pin");

  property p_analog_default;
    s_q.init == INIT_LOAD && !(wr_en && addr == REG_ANSEL_HI)
      |=> s_q.ansel == ($past(s_q.cfg_s2[BIT_CFG_ANALOG]) ? MASK_ANSEL[4:0] : 5'h00);
  endproperty
  a_analog_default: assert property (p_analog_default) else $error("analog default not applied");

  property p_unimpl_zero;
    (rd_en && addr == REG_B_CHG_EN) |=> rdata[3:0] == 4'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

  property p_change_flag;
    |chg_hit |=> s_q.chg_flag;
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("change flag not set");

  property p_stat_clear;
    (rd_en && addr == REG_IRQ_STAT && irq_ev == 2'h0) |=> s_q.stat == 2'h0;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

  // Enabled change flag going high must reach the interrupt line when unmasked
  sequence s_chg_rise;
    s_q.chg_flag && s_q.chg_ie && !$past(s_q.chg_flag && s_q.chg_ie);
  endsequence

  property p_change_irq;
    s_chg_rise ##0 (s_q.mask[BIT_STAT_CHG] && !(wr_en && addr == REG_IRQ_MASK)) |=> irq;
  endproperty
  a_change_irq: assert property (p_change_irq) else $error("change interrupt not raised");

  property p_stat_prog;
    $rose(prog_en) |=> s_q.stat[BIT_STAT_PROG];
  endproperty
  a_stat_prog: assert property (p_stat_prog) else $error("programming entry not flagged");

  property p_b_dir;
    (!prog_en && !ccp_on_b) |=> second_port_pin_levels_oe == ~$past(s_q.second_port_direction);
  endproperty
  a_b_dir: assert property (p_b_dir) else $error("second port drive not from direction");

  property p_c_pins_read;
    (rd_en && addr == REG_C_PINS) |=> rdata == $past(s_q.c_s2);
  endproperty
  a_c_pins_read: assert property (p_c_pins_read) else $error("third port pin read wrong");

  property p_unimpl_slew;
    (rd_en && addr == REG_SLEW) |=> rdata[7:5] == 3'h0;
  endproperty
  a_unimpl_slew: assert property (p_unimpl_slew) else $error("slew upper bits read nonzero");

endmodule : gpp_port

// [bench/gpp_pin_model.sv]
`timescale 1ns/1ps
module gpp_pin_model (
  // Second port
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_pu,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] ext_b_en,
  output logic [7:0] b_pin,
  // Third port
  input wire logic [7:0] c_out,
  input wire logic [7:0] c_oe,
  input wire logic [7:0] ext_c,
  output logic [7:0] c_pin
);
  // A released, unpulled second-port pin with no external drive shows the inverse of its output value, never a stale level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (b_oe[i]) b_pin[i] = b_out[i];
      else if (ext_b_en[i]) b_pin[i] = ext_b[i];
      else if (b_pu[i]) b_pin[i] = 1'b1;
      else b_pin[i] = ~b_out[i];
      c_pin[i] = c_oe[i] ? c_out[i] : ext_c[i];
    end
  end
endmodule : gpp_pin_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import gpp_pkg::*;
  logic clk, rst_n, wr_en, rd_en, cfg_relocate, cfg_analog_default, irq;
  logic capture_compare_unit_two_en, capture_compare_unit_two_drive, capture_compare_unit_two_out, capture_compare_unit_two_in, prog_en, pgd_oe, pgd_out, pgc_clk, pgd_in;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, b_in, b_out, b_oe, b_pu, b_an, c_in, c_out, c_oe;
  logic [7:0] pc_en, pc_oe, pc_out, pc_in, ext_b, ext_c, ext_b_en;
  logic [4:0] slew;
  int error_cnt, total_checks;

  gpp_port i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .irq(irq), .cfg_relocate(cfg_relocate), .cfg_analog_default(cfg_analog_default),
    .second_port_pin_levels_in(b_in), .second_port_pin_levels_out(b_out), .second_port_pin_levels_oe(b_oe), .second_port_pin_levels_pullup(b_pu), .second_port_pin_levels_analog(b_an),
    .third_port_pin_levels_in(c_in), .third_port_pin_levels_out(c_out), .third_port_pin_levels_oe(c_oe), .slew_ctrl(slew), .periph_c_en(pc_en),
    .periph_c_oe(pc_oe), .periph_c_out(pc_out), .periph_c_in(pc_in), .capture_compare_unit_two_en(capture_compare_unit_two_en),
    .capture_compare_unit_two_drive(capture_compare_unit_two_drive), .capture_compare_unit_two_out(capture_compare_unit_two_out), .capture_compare_unit_two_in(capture_compare_unit_two_in), .prog_en(prog_en),
    .pgd_oe(pgd_oe), .pgd_out(pgd_out), .pgc_clk(pgc_clk), .pgd_in(pgd_in));

  gpp_pin_model i_pins (.b_out(b_out), .b_oe(b_oe), .b_pu(b_pu), .ext_b(ext_b), .ext_b_en(ext_b_en),
    .b_pin(b_in), .c_out(c_out), .c_oe(c_oe), .ext_c(ext_c), .c_pin(c_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd

  // Write followed by a read in the very next cycle
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : wr_rd

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    {wr_en, rd_en, capture_compare_unit_two_en, capture_compare_unit_two_drive, capture_compare_unit_two_out, prog_en, pgd_oe, pgd_out} = '0;
    {cfg_relocate, cfg_analog_default} = 2'b11;
    addr = '0;
    wdata = '0;
    {pc_en, pc_oe, pc_out, ext_b} = '0;
    ext_b_en = 8'hff;
    ext_c = 8'ha5;
    error_cnt = 0;
    total_checks = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    idle(5);
    chk(c_oe, 8'h00);
    chk(b_an, 8'h1f);
    rd(REG_C_DIR, 8'hff);
    rd(REG_C_LATCH, 8'h00);
    rd(REG_INT_EDGE, 8'h80);
    rd(REG_ANSEL_HI, 8'h1f);
    $display("test reset done");
    wr_rd(REG_C_LATCH, 8'h5a, 8'h5a);
    wr(REG_C_DIR, 8'hcf);
    idle(5);
    chk(c_oe, 8'h30);
    chk(c_out & 8'h30, 8'h10);
    rd(REG_C_LATCH, 8'h5a);
    rd(REG_C_PINS, 8'h95);
    chk(pc_in, 8'h95);
    $display("test direction done");
    pc_en <= 8'h01;
    pc_oe <= 8'h01;
    pc_out <= 8'h01;
    capture_compare_unit_two_en <= 1'b1;
    capture_compare_unit_two_drive <= 1'b1;
    capture_compare_unit_two_out <= 1'b1;
    idle(3);
    chk(c_oe, 8'h33);
    chk(c_out & 8'h03, 8'h03);
    rd(REG_C_DIR, 8'hcf);
    capture_compare_unit_two_drive <= 1'b0;
    idle(5);
    chk(c_oe, 8'h31);
    chk({7'h0, capture_compare_unit_two_in}, 8'h00);
    $display("test override done");
    wr(REG_SLEW, 8'hff);
    wr(REG_INT_EXT, 8'hff);
    wr(REG_B_CHG_EN, 8'hff);
    rd(REG_SLEW, 8'h1f);
    rd(REG_INT_EXT, 8'h00);
    rd(REG_B_CHG_EN, 8'hf0);
    rd(4'hf, 8'h00);
    chk({3'h0, slew}, 8'h1f);
    $display("test unimplemented done");
    wr(REG_B_CHG_EN, 8'h80);
    wr(REG_INT_MAIN, 8'h08);
    rd(REG_B_PINS, 8'h00);
    ext_b <= 8'h80;
    idle(6);
    chk({7'h0, irq}, 8'h00);
    rd(REG_INT_MAIN, 8'h09);
    wr(REG_IRQ_MASK, 8'h01);
    for (int n = 0; n < 10 && irq !== 1'b1; n++) idle(1);
    if (irq !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    chk({7'h0, irq}, 8'h01);
    rd(REG_IRQ_STAT, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rd(REG_B_PINS, 8'h80);
    wr(REG_INT_MAIN, 8'h08);
    rd(REG_INT_MAIN, 8'h08);
    $display("test change done");
    ext_b_en <= 8'h3f;
    wr(REG_B_PULLUP, 8'hc0);
    wr(REG_INT_EDGE, 8'h00);
    idle(2);
    chk(b_pu, 8'hc0);
    wr(REG_B_DIR, 8'h7f);
    idle(2);
    chk(b_pu, 8'h40);
    wr(REG_B_DIR, 8'hff);
    wr(REG_INT_EDGE, 8'h80);
    idle(2);
    chk(b_pu, 8'h00);
    wr(REG_INT_EDGE, 8'h00);
    $display("test pullup done");
    prog_en <= 1'b1;
    pgd_oe <= 1'b1;
    pgd_out <= 1'b1;
    ext_b <= 8'h40;
    ext_b_en <= 8'h7f;
    idle(5);
    chk(b_oe & 8'hc0, 8'h80);
    chk(b_out & 8'h80, 8'h80);
    chk(b_pu & 8'hc0, 8'h00);
    chk({7'h0, pgc_clk}, 8'h01);
    pgd_oe <= 1'b0;
    ext_b_en <= 8'hff;
    idle(5);
    chk({7'h0, pgd_in}, 8'h00);
    chk(b_oe & 8'hc0, 8'h00);
    $display("test programming done");
    // Second reset with both straps cleared: capture pin moves, analog pins start digital
    prog_en <= 1'b0;
    pgd_oe <= 1'b0;
    pc_en <= 8'h00;
    capture_compare_unit_two_en <= 1'b0;
    capture_compare_unit_two_drive <= 1'b1;
    capture_compare_unit_two_out <= 1'b1;
    {cfg_relocate, cfg_analog_default} <= 2'b00;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    idle(5);
    chk(c_oe, 8'h00);
    chk(b_an, 8'h00);
    rd(REG_ANSEL_HI, 8'h00);
    capture_compare_unit_two_en <= 1'b1;
    idle(5);
    chk(b_oe & 8'h08, 8'h08);
    chk(b_out & 8'h08, 8'h08);
    chk(c_oe, 8'h00);
    chk({7'h0, capture_compare_unit_two_in}, 8'h01);
    $display("test relocate done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
